// *** design/hpc_pkg.sv ***
/*
  Package for the hub port change flag block: field positions, feature
  selectors, port state encoding and the carrier structs.
  Assumes the request decoder and port state machine share these codes.
*/
package hpc_pkg;

  // ********************************************************************
  // Change field layout
  // ********************************************************************
  localparam int unsigned CHG_W = 16;
  localparam int unsigned BIT_CONN = 0;
  localparam int unsigned BIT_ENA = 1;
  localparam int unsigned BIT_SUSP = 2;
  localparam int unsigned BIT_OVC = 3;
  localparam int unsigned BIT_RST = 4;
  localparam int unsigned NUM_FLAGS = 5;
  localparam logic [15:0] CHG_RESET = 16'h0000;

  // ********************************************************************
  // Feature selectors of the change flags
  // ********************************************************************
  localparam logic [7:0] FSEL_C_CONN = 8'h10;
  localparam logic [7:0] FSEL_C_ENA = 8'h11;
  localparam logic [7:0] FSEL_C_SUSP = 8'h12;
  localparam logic [7:0] FSEL_C_OVC = 8'h13;
  localparam logic [7:0] FSEL_C_RST = 8'h14;

  // ********************************************************************
  // Port states as reported by the port state machine
  // ********************************************************************
  typedef enum logic [3:0] {
    PS_POWERED_OFF,
    PS_DISCONNECTED,
    PS_DISABLED,
    PS_RESETTING,
    PS_SPEED_EVAL,
    PS_ENABLED,
    PS_TRANSMIT,
    PS_SUSPENDED,
    PS_RESUMING,
    PS_SEND_EOP,
    PS_RESTART_S,
    PS_OTHER
  } hpc_port_state_e;

  // Feature request from the hub controller, valid for one cycle
  typedef struct packed {
    logic valid;
    logic isSet;
    logic [7:0] selector;
  } hpc_feat_req_s;

  // Port status and events from the port logic, same clock
  typedef struct packed {
    hpc_port_state_e state;
    logic connStatus;
    logic attachDetachEvt;
    logic enableStatus;
    logic portErrorEvt;
    logic resetInvalidIdle;
    logic ovcStatus;
    logic ovcOtherPowerOff;
    logic hubConfigured;
  } hpc_port_stat_s;

  // Answer to a feature request
  typedef struct packed {
    logic valid;
    logic reqError;
  } hpc_feat_ack_s;

endpackage

// *** design/hpc_port_change.sv ***
/*
  Port status change flags of one downstream hub port.
  Assumes request and port status inputs come from logic on sys_clk;
  the hub descriptor options arrive as static straps.
*/
//
// Functional notes
// - Flags record only port events, never direct host request effects.
// - Each flag clears on its ClearPortFeature request and on hub reset.
// - Setting flags by SetPortFeature optional; otherwise request error or no-op.
// - Connect change at bit 0, one when connect status changed.
// - Connect change set on attach or detach detection.
// - Connect, enable, suspend, reset changes cleared and held zero while powered off.
// - Enable change at bit 1, set on enable loss by port error.
// - Enable change may also set when reset leaves port disabled.
// - Suspend change at bit 2, set only after resume signaling ended.
// - Suspend change set on Resuming to SendEOP, Restart_S to Transmit.
// - Over-current change at bit 3, set on any over-current edge.
// - Over-current change also set on power-off by other port over-current.
// - Over-current change cleared while hub not configured or by request.
// - Without per-port over-current reporting the flag stays zero.
// - Reset change at bit 4, set on Resetting or Speed_eval to Enabled.
// - Bits 5 to 15 always read as zero.
`timescale 1ns/10ps
module hpc_port_change
  import hpc_pkg::*;
#(
  parameter bit SET_SUPPORT = 1'b0,
  parameter bit SET_ERROR = 1'b1,
  parameter bit PER_PORT_OVC = 1'b1,
  parameter bit INVALID_IDLE_FLAG = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire hpc_feat_req_s featReq,
  input wire hpc_port_stat_s portStat,
  output logic [15:0] portChangeFlags,
  output hpc_feat_ack_s featAck
);

  // ********************************************************************
  // Reset release
  // ********************************************************************
  logic rstSync1_r;
  logic rstSync2_r;
  logic rstLocal_b;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1_r <= 1'b0;
      rstSync2_r <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstSync2_r <= rstSync1_r;
    end
  end
  assign rstLocal_b = rstSync2_r;

  // ********************************************************************
  // Feature selector decode
  // ********************************************************************
  function automatic logic [NUM_FLAGS-1:0] selDecode(input logic [7:0] sel);
    logic [NUM_FLAGS-1:0] hit;
    hit = '0;
    hit[BIT_CONN] = (sel == FSEL_C_CONN);
    hit[BIT_ENA] = (sel == FSEL_C_ENA);
    hit[BIT_SUSP] = (sel == FSEL_C_SUSP);
    hit[BIT_OVC] = (sel == FSEL_C_OVC);
    hit[BIT_RST] = (sel == FSEL_C_RST);
    return hit;
  endfunction

  logic [NUM_FLAGS-1:0] selHit;
  logic [NUM_FLAGS-1:0] clrReq;
  logic [NUM_FLAGS-1:0] setReq;

  assign selHit = selDecode(featReq.selector);
  assign clrReq = (featReq.valid && !featReq.isSet) ? selHit : '0;
  assign setReq = (featReq.valid && featReq.isSet && SET_SUPPORT) ? selHit : '0;

  // ********************************************************************
  // Previous status for edge and transition detection
  // ********************************************************************
  hpc_port_state_e statePrev_r;
  logic enablePrev_r;
  logic ovcPrev_r;

  always_ff @(posedge sys_clk or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      statePrev_r <= PS_POWERED_OFF;
      enablePrev_r <= 1'b0;
      ovcPrev_r <= 1'b0;
    end else begin
      statePrev_r <= portStat.state;
      enablePrev_r <= portStat.enableStatus;
      ovcPrev_r <= portStat.ovcStatus;
    end
  end

  // ********************************************************************
  // Port events
  // ********************************************************************
  logic [NUM_FLAGS-1:0] evt;
  logic [NUM_FLAGS-1:0] holdClr;
  logic poweredOff;

  assign poweredOff = (portStat.state == PS_POWERED_OFF);

  always_comb begin
    evt = '0;
    evt[BIT_CONN] = portStat.attachDetachEvt;
    evt[BIT_ENA] = enablePrev_r && !portStat.enableStatus && portStat.portErrorEvt;
    if (INVALID_IDLE_FLAG && portStat.resetInvalidIdle) begin
      evt[BIT_ENA] = 1'b1;
    end
    evt[BIT_SUSP] = (statePrev_r == PS_RESUMING && portStat.state == PS_SEND_EOP) ||
                    (statePrev_r == PS_RESTART_S && portStat.state == PS_TRANSMIT);
    evt[BIT_OVC] = (ovcPrev_r != portStat.ovcStatus) || portStat.ovcOtherPowerOff;
    evt[BIT_RST] = (statePrev_r == PS_RESETTING || statePrev_r == PS_SPEED_EVAL) &&
                   portStat.state == PS_ENABLED;
  end

  always_comb begin
    holdClr = '0;
    holdClr[BIT_CONN] = poweredOff;
    holdClr[BIT_ENA] = poweredOff;
    holdClr[BIT_SUSP] = poweredOff;
    holdClr[BIT_RST] = poweredOff;
    holdClr[BIT_OVC] = !portStat.hubConfigured;
  end

  // ********************************************************************
  // Change flags
  // ********************************************************************
  logic [NUM_FLAGS-1:0] flags_r;

  // Events win over a request clear so no change is lost; hold states win over all
  generate
    for (genvar i = 0; i < NUM_FLAGS; i++) begin : gFlag
      logic flag_nxt;
      always_comb begin
        flag_nxt = flags_r[i];
        if (clrReq[i]) begin
          flag_nxt = 1'b0;
        end
        if (evt[i] || setReq[i]) begin
          flag_nxt = 1'b1;
        end
        if (holdClr[i]) begin
          flag_nxt = 1'b0;
        end
        if (i == BIT_OVC && !PER_PORT_OVC) begin
          flag_nxt = 1'b0;
        end
      end
      always_ff @(posedge sys_clk or negedge rstLocal_b) begin
        if (!rstLocal_b) begin
          flags_r[i] <= CHG_RESET[i];
        end else begin
          flags_r[i] <= flag_nxt;
        end
      end
    end
  endgenerate

  // ********************************************************************
  // Read view and request answer
  // ********************************************************************
  // field layout
  always_ff @(posedge sys_clk or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      portChangeFlags <= CHG_RESET;
    end else begin
      portChangeFlags <= {{(CHG_W-NUM_FLAGS){1'b0}}, flags_r};
    end
  end

  always_ff @(posedge sys_clk or negedge rstLocal_b) begin
    if (!rstLocal_b) begin
      featAck <= '0;
    end else begin
      featAck.valid <= featReq.valid && (|selHit);
      featAck.reqError <= featReq.valid && featReq.isSet && (|selHit) &&
                          !SET_SUPPORT && SET_ERROR;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstLocal_b);

  sequence sResumeDone;
    statePrev_r == PS_RESUMING && portStat.state == PS_SEND_EOP;
  endsequence

  sequence sRestartDone;
    statePrev_r == PS_RESTART_S && portStat.state == PS_TRANSMIT;
  endsequence

  sequence sResetDone;
    (statePrev_r == PS_RESETTING || statePrev_r == PS_SPEED_EVAL) &&
      portStat.state == PS_ENABLED;
  endsequence

  // Error-caused enable loss outside the powered-off hold
  sequence sEnaLost;
    enablePrev_r && !portStat.enableStatus && portStat.portErrorEvt && !poweredOff;
  endsequence

  // Forced power-off by another port while over-current is reported here
  sequence sOtherOff;
    portStat.ovcOtherPowerOff && portStat.hubConfigured && PER_PORT_OVC;
  endsequence

  // ********************************************************************
  // Setting conditions
  // ********************************************************************
  // Output register lags the flag by one edge, hence the extra cycle
  a_conn_attach_sets: assert property (portStat.attachDetachEvt && !poweredOff
    |=> ##1 portChangeFlags[BIT_CONN])
    else $error("connect change not set");
  a_ena_err_sets: assert property (sEnaLost |=> flags_r[BIT_ENA])
    else $error("enable change missed on port error");
  a_idle_sets: assert property (portStat.resetInvalidIdle && INVALID_IDLE_FLAG
    && !poweredOff |=> flags_r[BIT_ENA])
    else $error("enable change missed on invalid idle");
  a_resume_sets: assert property (sResumeDone |=> flags_r[BIT_SUSP])
    else $error("suspend change missed");
  a_restart_sets: assert property (sRestartDone |=> flags_r[BIT_SUSP])
    else $error("suspend change missed after restart");
  a_ovc_edge_sets: assert property ($changed(portStat.ovcStatus)
    && portStat.hubConfigured && PER_PORT_OVC |=> ##1 portChangeFlags[BIT_OVC])
    else $error("ovc change missed");
  a_other_off_sets: assert property (sOtherOff |=> flags_r[BIT_OVC])
    else $error("ovc change missed on forced power-off");
  a_reset_done_sets: assert property (sResetDone |=> flags_r[BIT_RST])
    else $error("reset change missed");

  // ********************************************************************
  // Only port events or set requests set a flag; reserved bits and layout
  // ********************************************************************
  // Without diagnostic set support no request may raise the connect change
  a_no_host_conn: assert property (!portStat.attachDetachEvt && !setReq[BIT_CONN]
    && !flags_r[BIT_CONN] |=> !flags_r[BIT_CONN])
    else $error("connect change without event");
  a_ena_only_error: assert property ($rose(flags_r[BIT_ENA]) |->
    $past(portStat.portErrorEvt || portStat.resetInvalidIdle || setReq[BIT_ENA]))
    else $error("enable change without error");
  a_resume_only: assert property ($rose(flags_r[BIT_SUSP]) |->
    $past(setReq[BIT_SUSP] || (statePrev_r == PS_RESUMING && portStat.state == PS_SEND_EOP)
    || (statePrev_r == PS_RESTART_S && portStat.state == PS_TRANSMIT)))
    else $error("suspend change before resume ended");
  a_reserved_zero: assert property (portChangeFlags[15:5] == 11'h000)
    else $error("reserved bits not zero");
  // Flag bits sit at their field positions one edge after the flag register
  a_field_layout: assert property (portChangeFlags[NUM_FLAGS-1:0] == $past(flags_r))
    else $error("change field out of place");

  // ********************************************************************
  // Clearing and holding
  // ********************************************************************
  a_powoff_clears: assert property (poweredOff |-> ##2
    (portChangeFlags[BIT_RST] == 1'b0 || !$past(poweredOff)))
    else $error("reset change not held off");
  a_powoff_hold: assert property (poweredOff |=>
    !flags_r[BIT_CONN] && !flags_r[BIT_ENA] && !flags_r[BIT_SUSP])
    else $error("change flag not held off");
  a_ovc_unconf_clr: assert property (!portStat.hubConfigured |=> !flags_r[BIT_OVC])
    else $error("ovc change not cleared");
  a_clear_works: assert property (clrReq[BIT_RST] && !evt[BIT_RST]
    && !setReq[BIT_RST] |=> !flags_r[BIT_RST])
    else $error("reset change not cleared");
  a_conn_clear: assert property (clrReq[BIT_CONN] && !evt[BIT_CONN]
    && !setReq[BIT_CONN] |=> !flags_r[BIT_CONN])
    else $error("connect change not cleared");
  // A set flag must survive its status returning to the old value
  a_flag_sticky: assert property (flags_r[BIT_CONN] && !clrReq[BIT_CONN]
    && !poweredOff |=> flags_r[BIT_CONN])
    else $error("connect change lost");
  a_ovc_sticky: assert property (flags_r[BIT_OVC] && !clrReq[BIT_OVC]
    && portStat.hubConfigured |=> flags_r[BIT_OVC])
    else $error("ovc change lost");

  // ********************************************************************
  // Request answers
  // ********************************************************************
  a_clear_answer: assert property (featReq.valid && !featReq.isSet && (|selHit)
    |=> featAck.valid && !featAck.reqError)
    else $error("clear request not answered");
  a_set_refused: assert property (featReq.valid && featReq.isSet && (|selHit)
    && !SET_SUPPORT |=> featAck.valid && featAck.reqError == SET_ERROR)
    else $error("set request answer wrong");
  a_miss_ignored: assert property (featReq.valid && !(|selHit) |=> !featAck.valid)
    else $error("answer to a foreign selector");

endmodule

// *** dv/hpc_host_model.sv ***
/*
  Host side model: issues one feature request at a time, takes the answer.
  Assumes the design answers on the same edge that takes the request.
*/
`timescale 1ns/10ps
module hpc_host_model
  import hpc_pkg::*;
(
  input wire logic sys_clk,
  input wire hpc_feat_ack_s featAck,
  output hpc_feat_req_s featReq
);
  initial featReq = '0;
  // Strobe stands one cycle; answer read once that edge has landed
  task automatic send(input logic isSet, input logic [7:0] sel,
                      output hpc_feat_ack_s ack);
    @(posedge sys_clk);
    #1;
    featReq = '{valid: 1'b1, isSet: isSet, selector: sel};
    @(posedge sys_clk);
    #1;
    ack = featAck;
    featReq = '0;
  endtask
endmodule

// *** dv/hpc_port_change_test.sv ***
/*
  Self-checking bench of the port change flags against a bench model.
  Assumes the design's default parameters and the host model.
*/
`timescale 1ns/10ps
module hpc_port_change_test
  import hpc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  hpc_feat_req_s featReq;
  hpc_feat_ack_s featAck;
  hpc_feat_ack_s ack;
  hpc_port_stat_s ps;
  logic [15:0] flags;
  logic [15:0] expFlags;
  logic [31:0] r;
  int miscompares = 0;
  int testsRun = 0;
  int seed = 32'h2cc09761;
  int bitOf[5] = '{0, 1, 1, 3, 3};

  always #4 sys_clk = ~sys_clk;

  hpc_port_change i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .featReq(featReq),
    .portStat(ps), .portChangeFlags(flags), .featAck(featAck));
  hpc_host_model i_host (.sys_clk(sys_clk), .featAck(featAck), .featReq(featReq));

  // ********************
  // Helpers
  // ********************
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Four edges cover the two-stage flag path plus state detection
  task automatic check_flags();
    tick(4);
    testsRun++;
    if (flags !== expFlags) begin
      miscompares++;
      $display("FAIL t=%0t flags got %h exp %h", $time, flags, expFlags);
    end
  endtask

  task automatic check_ack(input logic v, input logic e);
    testsRun++;
    if ({ack.valid, ack.reqError} !== {v, e}) begin
      miscompares++;
      $display("FAIL t=%0t ack got %h exp %h", $time, {ack.valid, ack.reqError}, {v, e});
    end
  endtask

  // Kinds: attach, enable lost by error, invalid idle, over-current toggle, other-port off
  task automatic evt(input int k);
    case (k)
      0: ps.attachDetachEvt = 1'b1;
      1: begin
        ps.enableStatus = 1'b0;
        ps.portErrorEvt = 1'b1;
      end
      2: ps.resetInvalidIdle = 1'b1;
      3: ps.ovcStatus = ~ps.ovcStatus;
      default: ps.ovcOtherPowerOff = 1'b1;
    endcase
    tick(1);
    {ps.attachDetachEvt, ps.portErrorEvt, ps.resetInvalidIdle, ps.ovcOtherPowerOff} = '0;
    ps.enableStatus = 1'b1;
    expFlags[bitOf[k]] = 1'b1;
  endtask

  task automatic clr(input logic [7:0] sel);
    logic hit;
    hit = sel inside {[8'h10:8'h14]};
    i_host.send(1'b0, sel, ack);
    if (hit) expFlags[sel[2:0]] = 1'b0;
    check_ack(hit, 1'b0);
    check_flags();
  endtask

  task automatic trans(input hpc_port_state_e a, input hpc_port_state_e b,
                       input logic sets, input int bi);
    ps.state = a;
    tick(2);
    ps.state = b;
    if (sets) expFlags[bi] = 1'b1;
    check_flags();
  endtask

  task automatic print_verdict();
    $display("Counts: %0d checks, %0d mismatches", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ********************
  // Tests
  // ********************
  initial begin
    #40000;
    miscompares++;
    print_verdict();
  end

  initial begin
    ps = '0;
    ps.state = PS_ENABLED;
    ps.enableStatus = 1'b1;
    ps.hubConfigured = 1'b1;
    expFlags = '0;
    tick(5);
    rst_b = 1'b1;
    tick(3);
    check_flags();
    ps.enableStatus = 1'b0;
    tick(1);
    ps.enableStatus = 1'b1;
    check_flags();
    for (int n = 0; n < 10; n++) begin
      evt(n % 5);
      check_flags();
      clr(8'h10 + 8'(bitOf[n % 5]));
    end
    $display("test events done");
    trans(PS_RESUMING, PS_ENABLED, 1'b0, 2);
    trans(PS_RESUMING, PS_SEND_EOP, 1'b1, 2);
    clr(FSEL_C_SUSP);
    trans(PS_RESTART_S, PS_TRANSMIT, 1'b1, 2);
    trans(PS_RESETTING, PS_ENABLED, 1'b1, 4);
    clr(FSEL_C_RST);
    trans(PS_SPEED_EVAL, PS_ENABLED, 1'b1, 4);
    $display("test transitions done");
    i_host.send(1'b1, FSEL_C_CONN, ack);
    check_ack(1'b1, 1'b1);
    check_flags();
    clr(8'h0f);
    evt(0);
    evt(3);
    ps.state = PS_POWERED_OFF;
    expFlags &= 16'h0008;
    check_flags();
    ps.hubConfigured = 1'b0;
    expFlags = '0;
    check_flags();
    ps.state = PS_DISCONNECTED;
    ps.hubConfigured = 1'b1;
    $display("test clearing done");
    repeat (8) begin
      r = $random(seed);
      evt(int'(r[2:0]) % 5);
      check_flags();
      clr(8'h0f + {5'h00, r[5:3]});
    end
    $display("test random done");
    print_verdict();
  end
endmodule
